// ==== tlsm_pkg.sv ====
// Shared constants and types for the torque limit and status monitor
package tlsm_pkg;
    // Register indices (word addresses on the plain port)
    localparam logic [3:0] ADDR_LIMIT_SWITCH_WORD = 4'h0;
    localparam logic [3:0] ADDR_MAX_TORQUE_WORD = 4'h1;
    localparam logic [3:0] ADDR_FWD_PRIMARY = 4'h2;
    localparam logic [3:0] ADDR_REV_PRIMARY = 4'h3;
    localparam logic [3:0] ADDR_FWD_SECOND = 4'h4;
    localparam logic [3:0] ADDR_REV_SECOND = 4'h5;
    localparam logic [3:0] ADDR_MAX_TORQUE1 = 4'h6;
    localparam logic [3:0] ADDR_DIR_CFG = 4'h7;
    localparam logic [3:0] ADDR_FOLLOW_LEVEL = 4'h8;
    localparam logic [3:0] ADDR_INPOS_RANGE = 4'h9;
    localparam logic [3:0] ADDR_SPEED_RANGE = 4'ha;
    localparam logic [3:0] ADDR_FILTER_FOLLOW = 4'hb;
    localparam logic [3:0] ADDR_FILTER_INPOS = 4'hc;
    localparam logic [3:0] ADDR_FILTER_SPEED = 4'hd;
    localparam logic [3:0] ADDR_STATUS = 4'he;
    localparam logic [3:0] ADDR_ACTIVE_LIMITS = 4'hf;
    // Field positions
    localparam int LIMIT2_SWITCH_ENABLE_BIT = 0;
    localparam int MAX_TORQUE_LIMIT1_ENABLE_BIT = 4;
    localparam int CW_FWD_SELECT_BIT = 11;
    localparam int CW_REV_SELECT_BIT = 12;
    localparam int SW_TARGET_REACHED_BIT = 10;
    localparam int SW_FOLLOW_ERR_BIT = 13;
    // Reset and special values; torque in 0.1 % units, 1000 = rated
    localparam logic [31:0] LIMIT_SWITCH_WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] MAX_TORQUE_WORD_RESET = 32'h0000_0010;
    localparam logic [15:0] TORQUE_LIMIT_RESET = 16'h2710;
    localparam logic [15:0] TORQUE_LIMIT_MAX = 16'h2710;
    localparam logic [31:0] FOLLOW_DISABLE_LEVEL = 32'h0fff_ffff;
    localparam logic [31:0] INPOS_ALWAYS_RANGE = 32'hffff_ffff;
    localparam logic [15:0] FILTER_TIME_RESET = 16'h0000;
    // Millisecond tick from a 10 MHz clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [13:0] MS_TICK_LAST = 14'(MS_CYCLES - 1);
    typedef enum logic [2:0] {
        TLSM_MODE_NONE = 3'h0,
        TLSM_MODE_CSP = 3'h1,
        TLSM_MODE_PP = 3'h3,
        TLSM_MODE_PT = 3'h2,
        TLSM_MODE_JOG = 3'h6,
        TLSM_MODE_PV = 3'h7
    } tlsm_mode_type;
endpackage

// ==== tlsm_qual_if.sv ====
// Link between the monitor and one filter timer
interface tlsm_qual_if;
    logic cond;
    logic forceOn;
    logic [15:0] filterTime;
    logic qualified;
    modport ctrl (output cond, output forceOn, output filterTime, input qualified);
    modport timer (input cond, input forceOn, input filterTime, output qualified);
endinterface

// ==== tlsm_filter_timer.sv ====
// Millisecond qualification timer for one status flag
module tlsm_filter_timer (
    input wire logic clk,
    input wire logic rstN,
    input wire logic msTick,
    tlsm_qual_if.timer q
);
    logic [16:0] count_reg;
    logic [16:0] count_next;
    logic qual_reg;
    logic qual_next;

    always_comb begin
        count_next = count_reg;
        qual_next = qual_reg;
        if (q.forceOn) begin
            qual_next = 1'b1;
        end else if (!q.cond) begin
            // Drop restarts timing and clears the flag at once
            count_next = '0;
            qual_next = 1'b0;
        end else if (q.filterTime == 16'h0000 || count_reg > {1'b0, q.filterTime}) begin
            // First tick may land at once, so one extra tick keeps the full time
            qual_next = 1'b1;
        end else if (msTick) begin
            count_next = count_reg + 17'h1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_reg <= '0;
            qual_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            qual_reg <= qual_next;
        end
    end

    assign q.qualified = qual_reg;
endmodule

// ==== torque_limit_and_status_monitor.sv ====
// Torque limit selection and statusword qualification for one axis

module torque_limit_and_status_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [15:0] controlWord,
    input wire logic [2:0] opMode,
    input wire logic [31:0] droopPulses,
    input wire logic [31:0] positionError,
    input wire logic [31:0] speedError,
    input wire logic [15:0] motorMaxTorque,
    input wire logic [15:0] torqueDemand,
    input wire logic demandNegative,
    output logic [15:0] statusWord,
    output logic [15:0] fwdLimitActive,
    output logic [15:0] revLimitActive,
    output logic [15:0] maxTorqueReport,
    output logic [15:0] torqueCmd,
    output logic torqueCmdNegative
);
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic rstN;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstN = rstSync2_reg;

    // Configuration registers
    logic [31:0] limitSwitchWord_reg;
    logic [31:0] limitSwitchWord_next;
    logic [31:0] maxTorqueWord_reg;
    logic [31:0] maxTorqueWord_next;
    logic [15:0] fwdPrimary_reg;
    logic [15:0] fwdPrimary_next;
    logic [15:0] revPrimary_reg;
    logic [15:0] revPrimary_next;
    logic [15:0] fwdSecond_reg;
    logic [15:0] fwdSecond_next;
    logic [15:0] revSecond_reg;
    logic [15:0] revSecond_next;
    logic [15:0] maxTorque1_reg;
    logic [15:0] maxTorque1_next;
    logic [1:0] dirCfg_reg;
    logic [1:0] dirCfg_next;
    logic [31:0] followLevel_reg;
    logic [31:0] followLevel_next;
    logic [31:0] inposRange_reg;
    logic [31:0] inposRange_next;
    logic [31:0] speedRange_reg;
    logic [31:0] speedRange_next;
    logic [15:0] followFilter_reg;
    logic [15:0] followFilter_next;
    logic [15:0] inposFilter_reg;
    logic [15:0] inposFilter_next;
    logic [15:0] speedFilter_reg;
    logic [15:0] speedFilter_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        limitSwitchWord_next = limitSwitchWord_reg;
        maxTorqueWord_next = maxTorqueWord_reg;
        fwdPrimary_next = fwdPrimary_reg;
        revPrimary_next = revPrimary_reg;
        fwdSecond_next = fwdSecond_reg;
        revSecond_next = revSecond_reg;
        maxTorque1_next = maxTorque1_reg;
        dirCfg_next = dirCfg_reg;
        followLevel_next = followLevel_reg;
        inposRange_next = inposRange_reg;
        speedRange_next = speedRange_reg;
        followFilter_next = followFilter_reg;
        inposFilter_next = inposFilter_reg;
        speedFilter_next = speedFilter_reg;
        if (regWr) begin
            case (regAddr)
                tlsm_pkg::ADDR_LIMIT_SWITCH_WORD: limitSwitchWord_next = regWdata;
                tlsm_pkg::ADDR_MAX_TORQUE_WORD: maxTorqueWord_next = regWdata;
                tlsm_pkg::ADDR_FWD_PRIMARY: fwdPrimary_next = regWdata[15:0];
                tlsm_pkg::ADDR_REV_PRIMARY: revPrimary_next = regWdata[15:0];
                tlsm_pkg::ADDR_FWD_SECOND: fwdSecond_next = regWdata[15:0];
                tlsm_pkg::ADDR_REV_SECOND: revSecond_next = regWdata[15:0];
                tlsm_pkg::ADDR_MAX_TORQUE1: maxTorque1_next = regWdata[15:0];
                tlsm_pkg::ADDR_DIR_CFG: dirCfg_next = regWdata[1:0];
                tlsm_pkg::ADDR_FOLLOW_LEVEL: followLevel_next = regWdata;
                tlsm_pkg::ADDR_INPOS_RANGE: inposRange_next = regWdata;
                tlsm_pkg::ADDR_SPEED_RANGE: speedRange_next = regWdata;
                tlsm_pkg::ADDR_FILTER_FOLLOW: followFilter_next = regWdata[15:0];
                tlsm_pkg::ADDR_FILTER_INPOS: inposFilter_next = regWdata[15:0];
                tlsm_pkg::ADDR_FILTER_SPEED: speedFilter_next = regWdata[15:0];
                default: ;
            endcase
        end
    end

    // Limit selection
    logic switchEn;
    logic limit1En;
    logic swapSecond;
    logic [15:0] secondFwd;
    logic [15:0] secondRev;
    logic [15:0] fwdPick;
    logic [15:0] revPick;
    logic [15:0] motorCap;
    logic [15:0] fwdLim_next;
    logic [15:0] revLim_next;
    logic [15:0] maxRep_next;

    always_comb begin
        switchEn = limitSwitchWord_reg[tlsm_pkg::LIMIT2_SWITCH_ENABLE_BIT];
        limit1En = maxTorqueWord_reg[tlsm_pkg::MAX_TORQUE_LIMIT1_ENABLE_BIT];
        // Either reflection alone swaps the second forward and reverse limits; both cancel
        swapSecond = dirCfg_reg[0] ^ dirCfg_reg[1];
        secondFwd = swapSecond ? revSecond_reg : fwdSecond_reg;
        secondRev = swapSecond ? fwdSecond_reg : revSecond_reg;
        fwdPick = fwdPrimary_reg;
        revPick = revPrimary_reg;
        if (switchEn && controlWord[tlsm_pkg::CW_FWD_SELECT_BIT]) begin
            fwdPick = secondFwd;
        end
        if (switchEn && controlWord[tlsm_pkg::CW_REV_SELECT_BIT]) begin
            revPick = secondRev;
        end
        // Limit 1 also caps both directions when enabled
        motorCap = motorMaxTorque;
        if (limit1En && maxTorque1_reg < motorCap) begin
            motorCap = maxTorque1_reg;
        end
        fwdLim_next = (fwdPick > motorCap) ? motorCap : fwdPick;
        revLim_next = (revPick > motorCap) ? motorCap : revPick;
        maxRep_next = limit1En ? maxTorque1_reg : motorMaxTorque;
    end

    // Torque clamp; forward covers CCW power and CW regen alike
    logic [15:0] torqueCmd_next;
    always_comb begin
        if (demandNegative) begin
            torqueCmd_next = (torqueDemand > revLimitActive) ? revLimitActive : torqueDemand;
        end else begin
            torqueCmd_next = (torqueDemand > fwdLimitActive) ? fwdLimitActive : torqueDemand;
        end
        // A zero limit leaves no torque in that direction
        if ((demandNegative ? revLimitActive : fwdLimitActive) == 16'h0000) begin
            torqueCmd_next = 16'h0000;
        end
    end

    // Status qualification
    logic msTick;
    logic [13:0] msCnt_reg;
    logic [13:0] msCnt_next;
    always_comb begin
        msCnt_next = (msCnt_reg == tlsm_pkg::MS_TICK_LAST) ? 14'h0000 : msCnt_reg + 14'h0001;
    end
    assign msTick = (msCnt_reg == tlsm_pkg::MS_TICK_LAST);

    tlsm_qual_if followQ ();
    tlsm_qual_if inposQ ();
    tlsm_qual_if speedQ ();

    logic posFollowMode;
    logic posInMode;
    logic velMode;
    always_comb begin
        posFollowMode = (opMode == tlsm_pkg::TLSM_MODE_CSP) || (opMode == tlsm_pkg::TLSM_MODE_PP)
            || (opMode == tlsm_pkg::TLSM_MODE_PT) || (opMode == tlsm_pkg::TLSM_MODE_JOG);
        posInMode = (opMode == tlsm_pkg::TLSM_MODE_PP) || (opMode == tlsm_pkg::TLSM_MODE_PT)
            || (opMode == tlsm_pkg::TLSM_MODE_JOG);
        velMode = (opMode == tlsm_pkg::TLSM_MODE_PV);
    end

    assign followQ.cond = posFollowMode && (followLevel_reg != tlsm_pkg::FOLLOW_DISABLE_LEVEL)
        && (droopPulses >= followLevel_reg);
    assign followQ.forceOn = 1'b0;
    assign followQ.filterTime = followFilter_reg;
    assign inposQ.cond = posInMode && (positionError <= inposRange_reg);
    assign inposQ.forceOn = inposRange_reg == tlsm_pkg::INPOS_ALWAYS_RANGE;
    assign inposQ.filterTime = inposFilter_reg;
    assign speedQ.cond = velMode && (speedError <= speedRange_reg);
    assign speedQ.forceOn = 1'b0;
    assign speedQ.filterTime = speedFilter_reg;

    tlsm_filter_timer followTimer (.clk(core_clk), .rstN(rstN), .msTick(msTick), .q(followQ));
    tlsm_filter_timer inposTimer (.clk(core_clk), .rstN(rstN), .msTick(msTick), .q(inposQ));
    tlsm_filter_timer speedTimer (.clk(core_clk), .rstN(rstN), .msTick(msTick), .q(speedQ));

    logic [15:0] statusWord_next;
    always_comb begin
        statusWord_next = 16'h0000;
        statusWord_next[tlsm_pkg::SW_FOLLOW_ERR_BIT] = followQ.qualified;
        statusWord_next[tlsm_pkg::SW_TARGET_REACHED_BIT] =
            velMode ? speedQ.qualified : inposQ.qualified;
    end

    always_comb begin
        case (regAddr)
            tlsm_pkg::ADDR_LIMIT_SWITCH_WORD: rdata_next = limitSwitchWord_reg;
            tlsm_pkg::ADDR_MAX_TORQUE_WORD: rdata_next = maxTorqueWord_reg;
            tlsm_pkg::ADDR_FWD_PRIMARY: rdata_next = {16'h0000, fwdPrimary_reg};
            tlsm_pkg::ADDR_REV_PRIMARY: rdata_next = {16'h0000, revPrimary_reg};
            tlsm_pkg::ADDR_FWD_SECOND: rdata_next = {16'h0000, fwdSecond_reg};
            tlsm_pkg::ADDR_REV_SECOND: rdata_next = {16'h0000, revSecond_reg};
            tlsm_pkg::ADDR_MAX_TORQUE1: rdata_next = {16'h0000, maxRep_next};
            tlsm_pkg::ADDR_DIR_CFG: rdata_next = {30'h0, dirCfg_reg};
            tlsm_pkg::ADDR_FOLLOW_LEVEL: rdata_next = followLevel_reg;
            tlsm_pkg::ADDR_INPOS_RANGE: rdata_next = inposRange_reg;
            tlsm_pkg::ADDR_SPEED_RANGE: rdata_next = speedRange_reg;
            tlsm_pkg::ADDR_FILTER_FOLLOW: rdata_next = {16'h0000, followFilter_reg};
            tlsm_pkg::ADDR_FILTER_INPOS: rdata_next = {16'h0000, inposFilter_reg};
            tlsm_pkg::ADDR_FILTER_SPEED: rdata_next = {16'h0000, speedFilter_reg};
            tlsm_pkg::ADDR_STATUS: rdata_next = {16'h0000, statusWord};
            tlsm_pkg::ADDR_ACTIVE_LIMITS: rdata_next = {revLimitActive, fwdLimitActive};
            default: rdata_next = 32'h0000_0000;
        endcase
        if (!regRd) begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            limitSwitchWord_reg <= tlsm_pkg::LIMIT_SWITCH_WORD_RESET;
            maxTorqueWord_reg <= tlsm_pkg::MAX_TORQUE_WORD_RESET;
            fwdPrimary_reg <= tlsm_pkg::TORQUE_LIMIT_RESET;
            revPrimary_reg <= tlsm_pkg::TORQUE_LIMIT_RESET;
            fwdSecond_reg <= tlsm_pkg::TORQUE_LIMIT_RESET;
            revSecond_reg <= tlsm_pkg::TORQUE_LIMIT_RESET;
            maxTorque1_reg <= tlsm_pkg::TORQUE_LIMIT_MAX;
            dirCfg_reg <= 2'h0;
            followLevel_reg <= 32'h0000_0000;
            inposRange_reg <= 32'h0000_0000;
            speedRange_reg <= 32'h0000_0000;
            followFilter_reg <= tlsm_pkg::FILTER_TIME_RESET;
            inposFilter_reg <= tlsm_pkg::FILTER_TIME_RESET;
            speedFilter_reg <= tlsm_pkg::FILTER_TIME_RESET;
            rdata_reg <= 32'h0000_0000;
            msCnt_reg <= 14'h0000;
            statusWord <= 16'h0000;
            fwdLimitActive <= 16'h0000;
            revLimitActive <= 16'h0000;
            maxTorqueReport <= 16'h0000;
            torqueCmd <= 16'h0000;
            torqueCmdNegative <= 1'b0;
        end else begin
            limitSwitchWord_reg <= limitSwitchWord_next;
            maxTorqueWord_reg <= maxTorqueWord_next;
            fwdPrimary_reg <= fwdPrimary_next;
            revPrimary_reg <= revPrimary_next;
            fwdSecond_reg <= fwdSecond_next;
            revSecond_reg <= revSecond_next;
            maxTorque1_reg <= maxTorque1_next;
            dirCfg_reg <= dirCfg_next;
            followLevel_reg <= followLevel_next;
            inposRange_reg <= inposRange_next;
            speedRange_reg <= speedRange_next;
            followFilter_reg <= followFilter_next;
            inposFilter_reg <= inposFilter_next;
            speedFilter_reg <= speedFilter_next;
            rdata_reg <= rdata_next;
            msCnt_reg <= msCnt_next;
            statusWord <= statusWord_next;
            fwdLimitActive <= fwdLim_next;
            revLimitActive <= revLim_next;
            maxTorqueReport <= maxRep_next;
            torqueCmd <= torqueCmd_next;
            torqueCmdNegative <= demandNegative;
        end
    end

    assign regRdata = rdata_reg;
endmodule

// ==== tlsm_checker.sv ====
// Port assertions for the torque limit and status monitor
module tlsm_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] opMode,
    input wire logic [15:0] motorMaxTorque,
    input wire logic demandNegative,
    input wire logic [15:0] statusWord,
    input wire logic [15:0] fwdLimitActive,
    input wire logic [15:0] revLimitActive,
    input wire logic [15:0] torqueCmd,
    input wire logic torqueCmdNegative
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    function automatic logic posMode(input logic [2:0] m);
        return m inside {tlsm_pkg::TLSM_MODE_CSP, tlsm_pkg::TLSM_MODE_PP,
                         tlsm_pkg::TLSM_MODE_PT, tlsm_pkg::TLSM_MODE_JOG};
    endfunction
    a_status_spare_zero: assert property ((statusWord & 16'hdbff) == 16'h0000)
        else $error("statusword spare bits set");
    // Three samples cover the two-flop path from mode to statusword
    a_follow_pos_mode: assert property ((!posMode(opMode) && !posMode($past(opMode))
        && !posMode($past(opMode, 2))) |-> !statusWord[13])
        else $error("following error outside position modes");
    a_fwd_below_max: assert property ((motorMaxTorque == $past(motorMaxTorque)
        && motorMaxTorque == $past(motorMaxTorque, 2)) |-> fwdLimitActive <= motorMaxTorque)
        else $error("forward limit above motor maximum");
    a_rev_below_max: assert property ((motorMaxTorque == $past(motorMaxTorque)
        && motorMaxTorque == $past(motorMaxTorque, 2)) |-> revLimitActive <= motorMaxTorque)
        else $error("reverse limit above motor maximum");
    a_cmd_dir_copy: assert property (($past(nrst) && $past(nrst, 2) && $past(nrst, 3))
        |-> torqueCmdNegative == $past(demandNegative))
        else $error("torque direction not carried");
    a_cmd_fwd_limit: assert property ((!torqueCmdNegative && $stable(fwdLimitActive))
        |-> torqueCmd <= fwdLimitActive)
        else $error("forward torque above active limit");
    a_cmd_rev_limit: assert property ((torqueCmdNegative && $stable(revLimitActive))
        |-> torqueCmd <= revLimitActive)
        else $error("reverse torque above active limit");
    a_zero_limit_idle: assert property ((!torqueCmdNegative && fwdLimitActive == 16'h0000
        && $past(fwdLimitActive) == 16'h0000) |-> torqueCmd == 16'h0000)
        else $error("torque produced against zero limit");
endmodule

bind torque_limit_and_status_monitor tlsm_checker u_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .opMode(opMode),
    .motorMaxTorque(motorMaxTorque),
    .demandNegative(demandNegative),
    .statusWord(statusWord),
    .fwdLimitActive(fwdLimitActive),
    .revLimitActive(revLimitActive),
    .torqueCmd(torqueCmd),
    .torqueCmdNegative(torqueCmdNegative)
);

// ==== tlsm_ctrl_model.sv ====
// Motion controller model driving controlword selects and operation mode
module tlsm_ctrl_model (
    input wire logic clk,
    input wire logic fwdSel,
    input wire logic revSel,
    input wire logic [2:0] modeReq,
    output logic [15:0] controlWord,
    output logic [2:0] opMode
);
    timeunit 1ns;
    timeprecision 1ns;
    // Cyclic frame update; mapped objects are never written behind its back
    always_ff @(posedge clk) begin
        controlWord <= {3'h0, revSel, fwdSel, 11'h000};
        opMode <= modeReq;
    end
endmodule

// ==== torque_limit_and_status_monitor_tb.sv ====
// Register and status tests for the torque limit and status monitor
module torque_limit_and_status_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, nrst, regWr, regRd, fwdSel, revSel, demandNegative, torqueCmdNegative;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, droopPulses, positionError, speedError;
    logic [2:0] opModeReq, opMode;
    logic [15:0] controlWord, motorMaxTorque, torqueDemand, statusWord;
    logic [15:0] fwdLimitActive, revLimitActive, maxTorqueReport, torqueCmd, expS;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    tlsm_pkg::tlsm_mode_type modes [6] = '{tlsm_pkg::TLSM_MODE_NONE, tlsm_pkg::TLSM_MODE_CSP,
        tlsm_pkg::TLSM_MODE_PP, tlsm_pkg::TLSM_MODE_PT, tlsm_pkg::TLSM_MODE_JOG,
        tlsm_pkg::TLSM_MODE_PV};
    tlsm_ctrl_model ctrl (.clk(core_clk), .fwdSel(fwdSel), .revSel(revSel),
        .modeReq(opModeReq), .controlWord(controlWord), .opMode(opMode));
    torque_limit_and_status_monitor dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .controlWord(controlWord), .opMode(opMode), .droopPulses(droopPulses),
        .positionError(positionError), .speedError(speedError),
        .motorMaxTorque(motorMaxTorque), .torqueDemand(torqueDemand),
        .demandNegative(demandNegative), .statusWord(statusWord),
        .fwdLimitActive(fwdLimitActive), .revLimitActive(revLimitActive),
        .maxTorqueReport(maxTorqueReport), .torqueCmd(torqueCmd),
        .torqueCmdNegative(torqueCmdNegative));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Filter test needs up to two milliseconds of cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            tally_and_finish;
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk32(regRdata, exp);
    endtask
    task automatic settle;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic lim(input logic [15:0] f, input logic [15:0] r);
        settle;
        chk16(fwdLimitActive, f);
        chk16(revLimitActive, r);
    endtask
    initial begin
        nrst = 1'b0;
        {regAddr, regWdata, regWr, regRd, fwdSel, revSel, opModeReq} = '0;
        {droopPulses, positionError, speedError, torqueDemand, demandNegative} = '0;
        motorMaxTorque = 16'h2710;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(tlsm_pkg::ADDR_LIMIT_SWITCH_WORD, 32'h0);
        rd(tlsm_pkg::ADDR_MAX_TORQUE_WORD, 32'h10);
        rd(tlsm_pkg::ADDR_FWD_SECOND, 32'h2710);
        rd(tlsm_pkg::ADDR_REV_SECOND, 32'h2710);
        rd(tlsm_pkg::ADDR_FILTER_FOLLOW, 32'h0);
        rd(tlsm_pkg::ADDR_FILTER_INPOS, 32'h0);
        rd(tlsm_pkg::ADDR_FILTER_SPEED, 32'h0);
        $display("test reset values done");
        wr(tlsm_pkg::ADDR_MAX_TORQUE_WORD, 32'h0);
        wr(tlsm_pkg::ADDR_FWD_PRIMARY, 32'h01f4);
        wr(tlsm_pkg::ADDR_REV_PRIMARY, 32'h0258);
        wr(tlsm_pkg::ADDR_FWD_SECOND, 32'h012c);
        wr(tlsm_pkg::ADDR_REV_SECOND, 32'h00c8);
        settle;
        chk16(maxTorqueReport, 16'h2710);
        for (int i = 0; i < 8; i++) begin
            wr(tlsm_pkg::ADDR_LIMIT_SWITCH_WORD, {31'h0, i[2]});
            fwdSel <= i[0];
            revSel <= i[1];
            lim((i[2] && i[0]) ? 16'h012c : 16'h01f4, (i[2] && i[1]) ? 16'h00c8 : 16'h0258);
        end
        for (int j = 0; j < 4; j++) begin
            wr(tlsm_pkg::ADDR_DIR_CFG, 32'(j));
            lim((j[0] ^ j[1]) ? 16'h00c8 : 16'h012c, (j[0] ^ j[1]) ? 16'h012c : 16'h00c8);
        end
        wr(tlsm_pkg::ADDR_DIR_CFG, 32'h0);
        motorMaxTorque <= 16'h00fa;
        lim(16'h00fa, 16'h00c8);
        wr(tlsm_pkg::ADDR_MAX_TORQUE1, 32'h0064);
        wr(tlsm_pkg::ADDR_MAX_TORQUE_WORD, 32'h10);
        lim(16'h0064, 16'h0064);
        chk16(maxTorqueReport, 16'h0064);
        wr(tlsm_pkg::ADDR_MAX_TORQUE_WORD, 32'h0);
        settle;
        chk16(maxTorqueReport, 16'h00fa);
        rd(tlsm_pkg::ADDR_MAX_TORQUE1, 32'h00fa);
        @(posedge core_clk) motorMaxTorque <= 16'h2710;
        wr(tlsm_pkg::ADDR_FWD_SECOND, 32'h0);
        torqueDemand <= 16'h0100;
        lim(16'h0000, 16'h00c8);
        chk16(torqueCmd, 16'h0000);
        @(posedge core_clk) demandNegative <= 1'b1;
        settle;
        chk16(torqueCmd, 16'h00c8);
        chk16({15'h0000, torqueCmdNegative}, 16'h0001);
        @(posedge core_clk) demandNegative <= 1'b0;
        $display("test torque limits done");
        wr(tlsm_pkg::ADDR_INPOS_RANGE, 32'ha);
        wr(tlsm_pkg::ADDR_SPEED_RANGE, 32'h7);
        wr(tlsm_pkg::ADDR_FOLLOW_LEVEL, 32'h64);
        droopPulses <= 32'h64;
        positionError <= 32'h5;
        speedError <= 32'h8;
        foreach (modes[m]) begin
            @(posedge core_clk) opModeReq <= modes[m];
            expS = (modes[m] inside {tlsm_pkg::TLSM_MODE_CSP, tlsm_pkg::TLSM_MODE_PP,
                tlsm_pkg::TLSM_MODE_PT, tlsm_pkg::TLSM_MODE_JOG}) ? 16'h2000 : 16'h0000;
            if (modes[m] inside {tlsm_pkg::TLSM_MODE_PP, tlsm_pkg::TLSM_MODE_PT,
                tlsm_pkg::TLSM_MODE_JOG}) expS = expS | 16'h0400;
            settle;
            chk16(statusWord, expS);
        end
        @(posedge core_clk) speedError <= 32'h7;
        settle;
        chk16(statusWord, 16'h0400);
        @(posedge core_clk) speedError <= 32'h8;
        settle;
        chk16(statusWord, 16'h0000);
        @(posedge core_clk) opModeReq <= tlsm_pkg::TLSM_MODE_CSP;
        droopPulses <= 32'h63;
        settle;
        chk16(statusWord, 16'h0000);
        wr(tlsm_pkg::ADDR_FOLLOW_LEVEL, tlsm_pkg::FOLLOW_DISABLE_LEVEL);
        droopPulses <= 32'hffffffff;
        settle;
        chk16(statusWord, 16'h0000);
        @(posedge core_clk) droopPulses <= 32'h0;
        positionError <= 32'hffff0000;
        wr(tlsm_pkg::ADDR_INPOS_RANGE, 32'hffffffff);
        settle;
        chk16(statusWord, 16'h0400);
        wr(tlsm_pkg::ADDR_STATUS, 32'hffffffff);
        rd(tlsm_pkg::ADDR_STATUS, 32'h0400);
        wr(tlsm_pkg::ADDR_INPOS_RANGE, 32'ha);
        wr(tlsm_pkg::ADDR_FOLLOW_LEVEL, 32'h64);
        wr(tlsm_pkg::ADDR_FILTER_FOLLOW, 32'h1);
        droopPulses <= 32'h64;
        repeat (9000) @(posedge core_clk);
        @(negedge core_clk);
        chk16(statusWord, 16'h0000);
        for (int k = 0; k < 12000 && statusWord[13] !== 1'b1; k++) @(negedge core_clk);
        chk16(statusWord, 16'h2000);
        @(posedge core_clk) droopPulses <= 32'h0;
        settle;
        chk16(statusWord, 16'h0000);
        $display("test status flags done");
        tally_and_finish;
    end
endmodule
